/* core/pwr_seq_params.svh */
// Register offsets, field positions, reset values and timing figures of the power sequencer
`ifndef PWR_SEQ_PARAMS_SVH
`define PWR_SEQ_PARAMS_SVH

// Register byte offsets
`define OFS_MODE_CTRL    8'h00
`define OFS_CLK_SEL      8'h04
`define OFS_OSC_PLL      8'h08
`define OFS_CPU_DIV      8'h0C
`define OFS_USB_DIV      8'h10
`define OFS_PCLK_EN      8'h14
`define OFS_PCLK_DIV     8'h18
`define OFS_STATUS       8'h1C

// Field positions in the oscillator / PLL control word
`define BIT_MAIN_OSC_EN  0
`define BIT_PLL_EN       1
`define BIT_PLL_CONNECT  2

// Reset values
`define RST_CLK_SEL      2'h0
`define RST_OSC_PLL      3'h0
`define RST_CPU_DIV      8'h00
`define RST_USB_DIV      4'h0

// Timing figures
`define MCLK_MHZ         32'h0000_0032
`define IRC_START_US     32'h0000_003C
`define WAKE_IRC_CYC     16'h0004
`define WAKE_MAIN_CYC    16'h1000
`define RESET_HOLD_CYC   16'h0040

`endif

/* core/pwr_seq_pkg.sv */
// Types shared by the power-mode and wake-up sequencer
package pwr_seq_pkg;

  // Software mode requests
  typedef enum logic [2:0] {
    MODE_NONE  = 3'b000,
    MODE_IDLE  = 3'b001,
    MODE_SLEEP = 3'b010,
    MODE_PDOWN = 3'b011,
    MODE_DEEP  = 3'b100
  } mode_req_t;

  // Clock source selection
  typedef enum logic [1:0] {
    SRC_IRC  = 2'b00,
    SRC_MAIN = 2'b01,
    SRC_RTC  = 2'b10
  } clk_src_t;

  // Sequencer states
  typedef enum logic [3:0] {
    ST_RESET     = 4'b0000,
    ST_RUN       = 4'b0001,
    ST_IDLE      = 4'b0010,
    ST_SLEEP     = 4'b0011,
    ST_PDOWN     = 4'b0100,
    ST_IRC_START = 4'b0101,
    ST_WAKE      = 4'b0110,
    ST_DEEP      = 4'b0111
  } pwr_state_t;

  // Power and clock control outputs
  typedef struct packed {
    logic sys_resetn;
    logic core_run;
    logic periph_clk_on;
    logic irc_out_en;
    logic irc_power;
    logic main_osc_en;
    logic rtc_osc_en;
    logic pll_en;
    logic pll_connect;
    logic regulator_en;
    logic pin_hold;
  } pwr_ctrl_t;

  // Wake-up sources
  typedef struct packed {
    logic periph_irq;
    logic clockless_irq;
    logic rtc_alarm;
  } wake_src_t;

endpackage

/* core/power_mode_wakeup_control.sv */
// Power-mode sequencer, wake-up timer and peripheral clock gating
//
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`include "pwr_seq_params.svh"

// Functional notes
// [RQ1] Reset and deep wakes run from internal_rc_oscillator
// [RQ2] Software stabilises main oscillator before selecting it
// [RQ3] Wake timer waits for main oscillator good
// [RQ4] Every power-down wake passes the wake timer
// [RQ5] Idle halts execution until reset or interrupt
// [RQ6] Peripherals keep running and wake from Idle
// [RQ7] Sleep stops oscillator and all internal clocks
// [RQ8] Sleep retains state and holds pin levels
// [RQ9] Sleep gates oscillator output, keeps it powered
// [RQ10] Real-time clock oscillator runs during Sleep
// [RQ11] Sleep entry disables PLL, zeroes clock dividers
// [RQ12] Sleep ends on reset or clockless interrupt
// [RQ13] Sleep wake waits 4 or 4096 cycles
// [RQ14] Power-down also powers off internal oscillator
// [RQ15] Power-down wake waits 60 us plus 4
// [RQ16] Software reprograms PLL and dividers after wake
// [RQ17] Deep power-down drops regulator, full reset resume
// [RQ18] Deep power-down wakes on alarm or reset
// [RQ19] Restored power restarts from deep power-down
// [RQ20] Each peripheral has its own clock gate
// [RQ21] Each peripheral has its own clock divider
// [RQ22] Reset holds until pin released and count
// [RQ23] Mode entered only after its write completes
module power_mode_wakeup_control
  import pwr_seq_pkg::*;
#(
  parameter int NPERIPH = 8
) (
  input  wire logic                 mclk,
  input  wire logic                 resetn,
  input  wire logic [7:0]           reg_addr,
  input  wire logic [31:0]          reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output      logic [31:0]          reg_rdata,
  input  wire logic                 reset_pin_n,
  input  wire logic                 main_osc_ok,
  input  wire logic                 power_good,
  input  wire wake_src_t            wake_src,
  output      pwr_ctrl_t            pwr_ctrl,
  output      clk_src_t             proc_clk_sel,
  output      logic [7:0]           processor_clock_div,
  output      logic [3:0]           usb_clk_div,
  output      logic [NPERIPH-1:0]   periph_clk_tick
);

  localparam logic [15:0] IRC_START_CYC = 16'(`IRC_START_US * `MCLK_MHZ);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] pin_s1_ff;
  logic [2:0] pin_s2_ff;
  logic [2:0] pin_s3_ff;
  logic [2:0] pin_ff;
  logic       rst_pin_ok;
  logic       osc_ok;
  logic       pwr_ok;
  logic       pwr_ok_d_ff;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pin_s1_ff <= 3'h0;
      pin_s2_ff <= 3'h0;
      pin_s3_ff <= 3'h0;
    end else begin
      pin_s1_ff <= {power_good, main_osc_ok, reset_pin_n};
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pin_ff <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (pin_s2_ff[i] == pin_s3_ff[i]) begin
          pin_ff[i] <= pin_s3_ff[i];
        end
      end
    end
  end

  assign rst_pin_ok = pin_ff[0];
  assign osc_ok     = pin_ff[1];
  assign pwr_ok     = pin_ff[2];

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pwr_ok_d_ff <= 1'b0;
    end else begin
      pwr_ok_d_ff <= pwr_ok;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  pwr_state_t             state_ff;
  pwr_state_t             nxt_state;
  mode_req_t              mode_req_ff;
  clk_src_t               clk_sel_ff;
  logic [2:0]             osc_pll_ff;
  logic [7:0]             cpu_div_ff;
  logic [3:0]             usb_div_ff;
  logic [NPERIPH-1:0]     pclk_en_ff;
  logic [2*NPERIPH-1:0]   pclk_div_ff;
  logic                   sleep_entry;
  logic                   wr_hit;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  assign sleep_entry = (state_ff == ST_RUN) && (nxt_state == ST_SLEEP || nxt_state == ST_PDOWN);
  assign wr_hit      = reg_wr && hit(reg_addr, `OFS_MODE_CTRL);

  // Mode request is latched on the write and acted on next cycle
  always_ff @(posedge mclk) begin
    if (!resetn || state_ff == ST_RESET) begin
      mode_req_ff <= MODE_NONE;
    end else if (wr_hit) begin
      mode_req_ff <= mode_req_t'(reg_wdata[2:0]); // RQ23
    end else if (state_ff == ST_RUN) begin
      mode_req_ff <= MODE_NONE;
    end
  end

  // Clock source: forced to the internal oscillator on reset and power-down wake
  always_ff @(posedge mclk) begin
    if (!resetn || state_ff == ST_RESET) begin
      clk_sel_ff <= clk_src_t'(`RST_CLK_SEL); // RQ1
    end else if (state_ff == ST_PDOWN) begin
      clk_sel_ff <= SRC_IRC; // RQ1
    end else if (reg_wr && hit(reg_addr, `OFS_CLK_SEL)) begin
      clk_sel_ff <= clk_src_t'(reg_wdata[1:0]);
    end
  end

  // PLL and dividers: cleared by hardware on sleep entry
  always_ff @(posedge mclk) begin
    if (!resetn || state_ff == ST_RESET) begin
      osc_pll_ff <= `RST_OSC_PLL;
      cpu_div_ff <= `RST_CPU_DIV;
      usb_div_ff <= `RST_USB_DIV;
    end else if (sleep_entry) begin
      osc_pll_ff[`BIT_PLL_EN]      <= 1'b0; // RQ11
      osc_pll_ff[`BIT_PLL_CONNECT] <= 1'b0; // RQ11
      cpu_div_ff                   <= `RST_CPU_DIV; // RQ11
      usb_div_ff                   <= `RST_USB_DIV; // RQ11
    end else if (reg_wr) begin
      if (hit(reg_addr, `OFS_OSC_PLL)) begin
        osc_pll_ff <= reg_wdata[2:0];
      end else if (hit(reg_addr, `OFS_CPU_DIV)) begin
        cpu_div_ff <= reg_wdata[7:0];
      end else if (hit(reg_addr, `OFS_USB_DIV)) begin
        usb_div_ff <= reg_wdata[3:0];
      end
    end
  end

  // Peripheral gating and divider selects
  always_ff @(posedge mclk) begin
    if (!resetn || state_ff == ST_RESET) begin
      pclk_en_ff  <= '0;
      pclk_div_ff <= '0;
    end else if (reg_wr) begin
      if (hit(reg_addr, `OFS_PCLK_EN)) begin
        pclk_en_ff <= reg_wdata[NPERIPH-1:0]; // RQ20
      end else if (hit(reg_addr, `OFS_PCLK_DIV)) begin
        pclk_div_ff <= reg_wdata[2*NPERIPH-1:0]; // RQ21
      end
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      if (hit(reg_addr, `OFS_MODE_CTRL)) begin
        reg_rdata <= {29'h0, mode_req_ff};
      end else if (hit(reg_addr, `OFS_CLK_SEL)) begin
        reg_rdata <= {30'h0, clk_sel_ff};
      end else if (hit(reg_addr, `OFS_OSC_PLL)) begin
        reg_rdata <= {29'h0, osc_pll_ff};
      end else if (hit(reg_addr, `OFS_CPU_DIV)) begin
        reg_rdata <= {24'h0, cpu_div_ff};
      end else if (hit(reg_addr, `OFS_USB_DIV)) begin
        reg_rdata <= {28'h0, usb_div_ff};
      end else if (hit(reg_addr, `OFS_PCLK_EN)) begin
        reg_rdata <= 32'(pclk_en_ff);
      end else if (hit(reg_addr, `OFS_PCLK_DIV)) begin
        reg_rdata <= 32'(pclk_div_ff);
      end else if (hit(reg_addr, `OFS_STATUS)) begin
        reg_rdata <= {26'h0, pwr_ok, osc_ok, state_ff};
      end else begin
        reg_rdata <= 32'h0000_0000;
      end
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer and wake-up timer
  // ----------------------------------------------------------------
  logic [15:0] cnt_ff;
  logic [15:0] wake_len_ff;
  logic        cnt_clr;
  logic        wake_hold;

  assign wake_hold = (state_ff == ST_WAKE) && (clk_sel_ff == SRC_MAIN) && !osc_ok; // RQ3

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_RESET: begin
        if (rst_pin_ok && cnt_ff == `RESET_HOLD_CYC - 16'h0001) begin
          nxt_state = ST_RUN; // RQ22
        end
      end
      ST_RUN: begin
        case (mode_req_ff)
          MODE_IDLE:  nxt_state = ST_IDLE; // RQ23
          MODE_SLEEP: nxt_state = ST_SLEEP;
          MODE_PDOWN: nxt_state = ST_PDOWN;
          MODE_DEEP:  nxt_state = ST_DEEP;
          default:    nxt_state = ST_RUN;
        endcase
      end
      ST_IDLE: begin
        if (wake_src.periph_irq || wake_src.clockless_irq || wake_src.rtc_alarm) begin
          nxt_state = ST_RUN; // RQ5 RQ6
        end
      end
      ST_SLEEP: begin
        if (wake_src.clockless_irq || wake_src.rtc_alarm) begin
          nxt_state = ST_WAKE; // RQ12 RQ4
        end
      end
      ST_PDOWN: begin
        if (wake_src.clockless_irq || wake_src.rtc_alarm) begin
          nxt_state = ST_IRC_START; // RQ4
        end
      end
      ST_IRC_START: begin
        if (cnt_ff == IRC_START_CYC - 16'h0001) begin
          nxt_state = ST_WAKE; // RQ15
        end
      end
      ST_WAKE: begin
        if (!wake_hold && cnt_ff == wake_len_ff - 16'h0001) begin
          nxt_state = ST_RUN; // RQ13
        end
      end
      ST_DEEP: begin
        if (wake_src.rtc_alarm || (pwr_ok && !pwr_ok_d_ff)) begin
          nxt_state = ST_RESET; // RQ18 RQ19 RQ17
        end
      end
      default: nxt_state = ST_RESET;
    endcase
    if (!rst_pin_ok) begin
      nxt_state = ST_RESET; // RQ22 RQ18
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state_ff <= ST_RESET;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign cnt_clr = (nxt_state != state_ff) || wake_hold || (state_ff == ST_RESET && !rst_pin_ok);

  always_ff @(posedge mclk) begin
    if (!resetn || cnt_clr) begin
      cnt_ff <= 16'h0000; // RQ3 RQ22
    end else if (cnt_ff != 16'hFFFF) begin
      cnt_ff <= cnt_ff + 16'h0001;
    end
  end

  // Wake length: sleep keeps its source, power-down always restarts on the internal oscillator
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      wake_len_ff <= `WAKE_IRC_CYC;
    end else if (state_ff == ST_SLEEP && nxt_state == ST_WAKE) begin
      wake_len_ff <= (clk_sel_ff == SRC_MAIN) ? `WAKE_MAIN_CYC : `WAKE_IRC_CYC; // RQ13
    end else if (state_ff == ST_IRC_START) begin
      wake_len_ff <= `WAKE_IRC_CYC; // RQ15
    end
  end

  // ----------------------------------------------------------------
  // Power and clock control outputs
  // ----------------------------------------------------------------
  pwr_ctrl_t nxt_ctrl;
  logic      nxt_stop;
  logic      nxt_pdn;

  always_comb begin
    nxt_stop               = (nxt_state == ST_SLEEP) || (nxt_state == ST_PDOWN) ||
                             (nxt_state == ST_DEEP) || (nxt_state == ST_IRC_START);
    nxt_pdn                = (nxt_state == ST_PDOWN) || (nxt_state == ST_DEEP) ||
                             (nxt_state == ST_IRC_START);
    nxt_ctrl               = '0;
    nxt_ctrl.sys_resetn    = (nxt_state != ST_RESET); // RQ22 RQ17
    nxt_ctrl.core_run      = (nxt_state == ST_RUN); // RQ5 RQ4
    nxt_ctrl.periph_clk_on = (nxt_state == ST_RUN) || (nxt_state == ST_IDLE); // RQ6 RQ7
    nxt_ctrl.irc_out_en    = !nxt_stop; // RQ9 RQ1
    nxt_ctrl.irc_power     = !((nxt_state == ST_PDOWN) || (nxt_state == ST_DEEP)); // RQ14 RQ9
    nxt_ctrl.main_osc_en   = osc_pll_ff[`BIT_MAIN_OSC_EN] && !nxt_pdn &&
                             (nxt_state != ST_SLEEP); // RQ7
    nxt_ctrl.rtc_osc_en    = 1'b1; // RQ10
    nxt_ctrl.pll_en        = osc_pll_ff[`BIT_PLL_EN] && !nxt_stop; // RQ11
    nxt_ctrl.pll_connect   = osc_pll_ff[`BIT_PLL_CONNECT] && !nxt_stop; // RQ11
    nxt_ctrl.regulator_en  = (nxt_state != ST_DEEP); // RQ17
    nxt_ctrl.pin_hold      = (nxt_state == ST_SLEEP) || (nxt_state == ST_PDOWN) ||
                             (nxt_state == ST_IRC_START); // RQ8
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pwr_ctrl            <= '0;
      proc_clk_sel        <= SRC_IRC;
      processor_clock_div <= `RST_CPU_DIV;
      usb_clk_div         <= `RST_USB_DIV;
    end else begin
      pwr_ctrl            <= nxt_ctrl;
      proc_clk_sel        <= clk_sel_ff; // RQ1
      processor_clock_div <= cpu_div_ff;
      usb_clk_div         <= usb_div_ff;
    end
  end

  // ----------------------------------------------------------------
  // Peripheral clock dividers
  // ----------------------------------------------------------------
  logic [2:0] pdiv_cnt_ff [NPERIPH];

  function automatic logic tick_due(input logic [2:0] c, input logic [1:0] sel);
    logic [2:0] mask;
    mask     = 3'((4'h1 << sel) - 4'h1);
    tick_due = ((c & mask) == 3'h0);
  endfunction

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      for (int i = 0; i < NPERIPH; i++) begin
        pdiv_cnt_ff[i] <= 3'h0;
      end
      periph_clk_tick <= '0;
    end else begin
      for (int i = 0; i < NPERIPH; i++) begin
        if (nxt_ctrl.periph_clk_on && pclk_en_ff[i]) begin
          pdiv_cnt_ff[i]     <= pdiv_cnt_ff[i] + 3'h1; // RQ21
          periph_clk_tick[i] <= tick_due(pdiv_cnt_ff[i], pclk_div_ff[2*i +: 2]); // RQ20
        end else begin
          pdiv_cnt_ff[i]     <= 3'h0;
          periph_clk_tick[i] <= 1'b0; // RQ20 RQ7
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  AST_RESET_HOLD: assert property ( // RQ22
    (state_ff == ST_RESET && !rst_pin_ok) |=> state_ff == ST_RESET)
    else $error("reset left while pin asserted");
  AST_IRC_AFTER_PDOWN: assert property ( // RQ1
    (state_ff == ST_IRC_START) |-> clk_sel_ff == SRC_IRC)
    else $error("clock source not internal oscillator after power-down");
  AST_WAKE_MAIN_WAIT: assert property ( // RQ3
    wake_hold |=> state_ff == ST_WAKE && cnt_ff == 16'h0000)
    else $error("wake timer ran without good main oscillator");
  AST_NO_DIRECT_RUN: assert property ( // RQ4
    ($rose(state_ff == ST_RUN) && $past(state_ff) != ST_IDLE) |->
    $past(state_ff) inside {ST_WAKE, ST_RESET})
    else $error("run resumed without wake timer");
  AST_IDLE_HALT: assert property ( // RQ5
    (state_ff == ST_IDLE) |-> !pwr_ctrl.core_run && pwr_ctrl.periph_clk_on)
    else $error("idle did not halt core or stopped peripherals");
  AST_IDLE_WAKE: assert property ( // RQ6
    (state_ff == ST_IDLE && wake_src.periph_irq && rst_pin_ok) |=> pwr_ctrl.core_run)
    else $error("peripheral interrupt did not wake idle");
  AST_SLEEP_CLOCKS: assert property ( // RQ7
    (state_ff == ST_SLEEP) |-> !pwr_ctrl.irc_out_en && pwr_ctrl.irc_power &&
    !pwr_ctrl.main_osc_en && periph_clk_tick == '0 && pwr_ctrl.rtc_osc_en)
    else $error("clocks not stopped correctly in sleep");
  AST_SLEEP_PLL: assert property ( // RQ11
    (state_ff == ST_RUN && nxt_state == ST_SLEEP) |=>
    cpu_div_ff == 8'h00 && usb_div_ff == 4'h0 && !osc_pll_ff[`BIT_PLL_EN])
    else $error("sleep entry did not clear PLL and dividers");
  AST_SLEEP_IRC_WAKE: assert property ( // RQ13
    (state_ff == ST_SLEEP && nxt_state == ST_WAKE && clk_sel_ff == SRC_IRC) |=>
    (state_ff == ST_WAKE && rst_pin_ok) [*4] ##1 state_ff == ST_RUN)
    else $error("sleep wake did not take four cycles");
  AST_PDOWN_IRC_OFF: assert property ( // RQ14
    (state_ff == ST_PDOWN) |-> !pwr_ctrl.irc_power && pwr_ctrl.pin_hold)
    else $error("internal oscillator powered in power-down");
  AST_PDOWN_START: assert property ( // RQ15
    (state_ff == ST_IRC_START && cnt_ff == IRC_START_CYC - 16'h0001 && rst_pin_ok) |=>
    state_ff == ST_WAKE && wake_len_ff == `WAKE_IRC_CYC)
    else $error("power-down start-up not followed by short wake");
  AST_DEEP_REG_OFF: assert property ( // RQ17
    (state_ff == ST_DEEP) |-> !pwr_ctrl.regulator_en)
    else $error("regulator on during deep power-down");
  AST_DEEP_WAKE: assert property ( // RQ18
    (state_ff == ST_DEEP && !wake_src.rtc_alarm && rst_pin_ok && !(pwr_ok && !pwr_ok_d_ff))
    |=> state_ff == ST_DEEP)
    else $error("deep power-down left without alarm or reset");
  AST_MODE_AFTER_WRITE: assert property ( // RQ23
    (state_ff == ST_RUN && wr_hit && reg_wdata[2:0] == MODE_IDLE && rst_pin_ok) |=>
    state_ff == ST_RUN ##1 state_ff == ST_IDLE)
    else $error("mode entered before write completed");

  COV_SLEEP_WAKE: cover property (state_ff == ST_SLEEP ##[1:100] state_ff == ST_WAKE);
  COV_PDOWN_WAKE: cover property ($fell(state_ff == ST_IRC_START) ##[1:8] state_ff == ST_RUN);
  COV_DEEP_RESET: cover property (state_ff == ST_DEEP ##1 state_ff == ST_RESET);
  COV_IDLE_WAKE:  cover property (state_ff == ST_IDLE ##1 state_ff == ST_RUN);

endmodule // power_mode_wakeup_control

/* bench/power_mode_wakeup_control_tb.sv */
// Self-checking testbench of the power-mode and wake-up sequencer
`timescale 1ns/1ps
`include "pwr_seq_params.svh"
module power_mode_wakeup_control_tb import pwr_seq_pkg::*;;
  localparam int B_SYS = 10;
  localparam int B_RUN = 9;
  localparam int B_PCK = 8;
  localparam int B_IRO = 7;
  localparam int B_IRP = 6;
  localparam int B_RTC = 4;
  localparam int B_PLL = 3;
  localparam int B_CON = 2;
  localparam int B_REG = 1;
  localparam int B_PIN = 0;
  logic               mclk        = 1'b0;
  logic               resetn      = 1'b0;
  logic [7:0]         reg_addr    = 8'h00;
  logic [31:0]        reg_wdata   = 32'h0;
  logic               reg_wr      = 1'b0;
  logic               reg_rd      = 1'b0;
  logic [31:0]        reg_rdata;
  logic               reset_pin_n = 1'b1;
  logic               main_osc_ok = 1'b1;
  logic               power_good  = 1'b1;
  wake_src_t          wake_src    = '0;
  pwr_ctrl_t          pwr_ctrl;
  clk_src_t           proc_clk_sel;
  logic [7:0]         processor_clock_div;
  logic [3:0]         usb_clk_div;
  logic [7:0]         periph_clk_tick;
  logic               rd_pend     = 1'b0;
  logic [31:0]        exp_q[$];
  int                 n_mismatch  = 0;
  int                 checks      = 0;
  int                 cyc         = 0;
  int                 seed        = 32'hB8ACEB03;

  power_mode_wakeup_control #(.NPERIPH(8)) power_mode_wakeup_control_inst (
    .mclk(mclk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reset_pin_n(reset_pin_n), .main_osc_ok(main_osc_ok), .power_good(power_good),
    .wake_src(wake_src), .pwr_ctrl(pwr_ctrl), .proc_clk_sel(proc_clk_sel),
    .processor_clock_div(processor_clock_div), .usb_clk_div(usb_clk_div),
    .periph_clk_tick(periph_clk_tick));

  always #10 mclk = ~mclk;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic chkb(input int b, input logic v);
    check($sformatf("pwr_ctrl[%0d]", b), {31'h0, pwr_ctrl[b]}, {31'h0, v});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    exp_q.push_back(e);
    @(posedge mclk);
    reg_rd <= 1'b0;
  endtask
  task automatic wait_bit(input int b, input logic v, input int lim, output int n);
    n = 0;
    while (pwr_ctrl[b] !== v && n < lim) begin
      @(posedge mclk);
      #1;
      n++;
    end
    check("wait bound", {31'h0, n < lim}, 32'h1);
  endtask
  task automatic pulse(input logic [2:0] w);
    @(posedge mclk);
    wake_src <= w;
    @(posedge mclk);
    wake_src <= 3'h0;
  endtask

  // ----------------------------------------
  // Read data monitor and timeout
  // ----------------------------------------
  always @(posedge mclk) begin
    rd_pend <= reg_rd;
    if (rd_pend) begin
      check("reg_rdata", reg_rdata, exp_q.pop_front());
    end
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      close_out();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    int n;
    int n_irc;
    int n_main;
    int n_pd;
    int tk[8];
    int e;
    logic [7:0] cdiv;
    logic [7:0] pen;
    repeat (6) @(posedge mclk);
    resetn <= 1'b1;
    wait_bit(B_SYS, 1'b1, 200, n);
    check("proc_clk_sel", {30'h0, proc_clk_sel}, {30'h0, SRC_IRC});
    chkb(B_IRO, 1'b1);
    rd(`OFS_STATUS, 32'h0000_0031);
    rd(`OFS_CLK_SEL, {30'h0, `RST_CLK_SEL});
    rd(`OFS_OSC_PLL, {29'h0, `RST_OSC_PLL});
    rd(`OFS_USB_DIV, {28'h0, `RST_USB_DIV});
    rd(8'h20, 32'h0);
    cdiv = 8'($random(seed)) | 8'h01;
    pen = 8'($random(seed));
    wr(`OFS_CPU_DIV, {24'h0, cdiv});
    wr(`OFS_USB_DIV, 32'h0000_0009);
    wr(`OFS_OSC_PLL, 32'h0000_0007);
    wr(`OFS_STATUS, 32'h0000_00FF);
    wr(`OFS_PCLK_EN, {24'h0, pen});
    wr(`OFS_PCLK_DIV, 32'h0000_E4E4);
    rd(`OFS_CPU_DIV, {24'h0, cdiv});
    rd(`OFS_STATUS, 32'h0000_0031);
    check("processor_clock_div", {24'h0, processor_clock_div}, {24'h0, cdiv});
    chkb(B_PLL, 1'b1);
    chkb(B_CON, 1'b1);
    for (int i = 0; i < 64; i++) begin
      @(posedge mclk);
      #1;
      for (int j = 0; j < 8; j++) tk[j] += periph_clk_tick[j];
    end
    for (int j = 0; j < 8; j++) begin
      e = pen[j] ? (64 >> (j % 4)) : 0;
      check("tick count", {31'h0, (tk[j] - e) <= pen[j] && (e - tk[j]) <= pen[j]}, 1);
    end
    wr(`OFS_MODE_CTRL, {29'h0, MODE_IDLE});
    wait_bit(B_RUN, 1'b0, 5, n);
    repeat (10) @(posedge mclk);
    #1;
    chkb(B_RUN, 1'b0);
    chkb(B_PCK, 1'b1);
    pulse(3'h4);
    wait_bit(B_RUN, 1'b1, 5, n);
    rd(`OFS_MODE_CTRL, 32'h0);
    wr(`OFS_MODE_CTRL, {29'h0, MODE_SLEEP});
    wait_bit(B_RUN, 1'b0, 5, n);
    @(posedge mclk);
    #1;
    chkb(B_IRO, 1'b0);
    chkb(B_IRP, 1'b1);
    chkb(B_RTC, 1'b1);
    chkb(B_PLL, 1'b0);
    chkb(B_CON, 1'b0);
    chkb(B_PIN, 1'b1);
    check("div", {20'h0, processor_clock_div, usb_clk_div}, 32'h0);
    pulse(3'h4);
    repeat (10) @(posedge mclk);
    #1;
    chkb(B_RUN, 1'b0);
    pulse(3'h2);
    wait_bit(B_RUN, 1'b1, 20, n_irc);
    rd(`OFS_CPU_DIV, 32'h0);
    wr(`OFS_CLK_SEL, {30'h0, SRC_MAIN});
    wr(`OFS_MODE_CTRL, {29'h0, MODE_SLEEP});
    wait_bit(B_RUN, 1'b0, 5, n);
    @(posedge mclk);
    main_osc_ok <= 1'b0;
    pulse(3'h1);
    repeat (100) @(posedge mclk);
    #1;
    chkb(B_RUN, 1'b0);
    rd(`OFS_STATUS, 32'h0000_0026);
    @(posedge mclk);
    main_osc_ok <= 1'b1;
    wait_bit(B_RUN, 1'b1, 6000, n_main);
    check("main wake", n_main - n_irc, `WAKE_MAIN_CYC + 4 - `WAKE_IRC_CYC);
    wr(`OFS_MODE_CTRL, {29'h0, MODE_PDOWN});
    wait_bit(B_RUN, 1'b0, 5, n);
    chkb(B_IRP, 1'b0);
    chkb(B_PIN, 1'b1);
    pulse(3'h2);
    wait_bit(B_RUN, 1'b1, 6000, n_pd);
    check("pdown wake", n_pd - n_irc, `IRC_START_US * `MCLK_MHZ);
    check("proc_clk_sel", {30'h0, proc_clk_sel}, {30'h0, SRC_IRC});
    wr(`OFS_CPU_DIV, 32'h0000_005A);
    wr(`OFS_MODE_CTRL, {29'h0, MODE_DEEP});
    wait_bit(B_REG, 1'b0, 5, n);
    pulse(3'h6);
    repeat (20) @(posedge mclk);
    #1;
    chkb(B_REG, 1'b0);
    pulse(3'h1);
    wait_bit(B_SYS, 1'b0, 5, n);
    wait_bit(B_SYS, 1'b1, 300, n);
    rd(`OFS_CPU_DIV, 32'h0);
    wr(`OFS_MODE_CTRL, {29'h0, MODE_DEEP});
    wait_bit(B_REG, 1'b0, 5, n);
    @(posedge mclk);
    power_good <= 1'b0;
    repeat (10) @(posedge mclk);
    power_good <= 1'b1;
    wait_bit(B_SYS, 1'b0, 10, n);
    wait_bit(B_SYS, 1'b1, 300, n);
    @(posedge mclk);
    reset_pin_n <= 1'b0;
    wait_bit(B_SYS, 1'b0, 10, n);
    @(posedge mclk);
    reset_pin_n <= 1'b1;
    wait_bit(B_SYS, 1'b1, 200, n);
    check("reset hold", {31'h0, n >= `RESET_HOLD_CYC}, 32'h1);
    repeat (4) @(posedge mclk);
    close_out();
  end
endmodule // power_mode_wakeup_control_tb
